/* File: inc/jtag_cmd_regs.svh */
`ifndef JTAG_CMD_REGS_SVH
`define JTAG_CMD_REGS_SVH

// ----------------------------------------
// command byte fields
// ----------------------------------------
`define CMD_KIND_BIT 7
`define TMS_PKT_TDI_BIT 6
`define HDR_SCAN 3'h4
`define OP_END_TMS_BIT 3
`define OP_CAPTURE_BIT 2
`define OP_FIXED_LVL_BIT 1
`define OP_FIXED_FLAG_BIT 0
`define LEN_PACKED_BIT 7

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define MAX_WR_BYTES 3'h4
`define LAST_BIT_IDX 3'h7
`define ONE_BIT_LEFT 8'h01
`define TCK_IDLE 1'b0
`define TMS_IDLE 1'b0
`define TDI_IDLE 1'b0

// ----------------------------------------
// link phases of one tck cycle
// ----------------------------------------
`define PH_RISE 2'h0
`define PH_SAMPLE 2'h3

`endif

/* File: inc/jtag_cmd_pkg.sv */
package jtag_cmd_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [31:0] word_type;
  typedef logic [2:0] count_type;

  // decoder states, one-hot
  typedef enum logic [4:0] {
    S_OP   = 5'h01,
    S_LEN  = 5'h02,
    S_DATA = 5'h04,
    S_BIT  = 5'h08,
    S_WAIT = 5'h10
  } state_type;
endpackage

/* File: inc/scan_link_if.sv */
`timescale 1ns/1ps
// one tck cycle request from the decoder, answered from the link domain
interface scan_link_if;
  logic req_tgl;
  logic tms;
  logic tdi;
  logic ack_tgl;
  logic tdo_bit;

  modport eng (output req_tgl, output tms, output tdi, input ack_tgl, input tdo_bit);
  modport phy (input req_tgl, input tms, input tdi, output ack_tgl, output tdo_bit);
endinterface

/* File: rtl/scan_link_phy.sv */
`timescale 1ns/1ps
`include "jtag_cmd_regs.svh"
module scan_link_phy (
  // link clock and reset
  input wire logic link_clk_i,
  input wire logic rst_i,
  // decoder side
  scan_link_if.phy lnk,
  // jtag pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  import jtag_cmd_pkg::*;

  logic rst_s1_q, link_rst_q;
  logic req_s1_q, req_s2_q, req_seen_q;
  logic tdo_s1_q, tdo_s2_q;
  logic busy_q;
  logic [1:0] ph_q;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // reset, request toggle and tdo each pass two flops
  always_ff @(posedge link_clk_i) begin
    rst_s1_q <= rst_i;
    link_rst_q <= rst_s1_q;
    req_s1_q <= lnk.req_tgl;
    req_s2_q <= req_s1_q;
    tdo_s1_q <= tdo_i;
    tdo_s2_q <= tdo_s1_q;
  end

  // ----------------------------------------
  // one tck cycle per request
  // ----------------------------------------
  // tms/tdi set with tck low, tck high for three phases, then sampled
  always_ff @(posedge link_clk_i) begin
    if (link_rst_q) begin
      tck_o <= `TCK_IDLE;
      tms_o <= `TMS_IDLE;
      tdi_o <= `TDI_IDLE;
      req_seen_q <= 1'b0;
      busy_q <= 1'b0;
      ph_q <= 2'h0;
      lnk.ack_tgl <= 1'b0;
      lnk.tdo_bit <= 1'b0;
    end else if (!busy_q) begin
      if (req_s2_q != req_seen_q) begin
        req_seen_q <= req_s2_q;
        tms_o <= lnk.tms; // R8
        tdi_o <= lnk.tdi; // R7
        busy_q <= 1'b1;
        ph_q <= `PH_RISE;
      end
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == `PH_RISE) begin
        tck_o <= 1'b1;
      end
      // tdo moves on the falling edge, so the synced copy is settled here
      if (ph_q == `PH_SAMPLE) begin
        tck_o <= `TCK_IDLE;
        lnk.tdo_bit <= tdo_s2_q;
        lnk.ack_tgl <= ~lnk.ack_tgl;
        busy_q <= 1'b0;
      end
    end
  end
endmodule

/* File: rtl/jtag_byte_engine.sv */
// Function
// [R1] a command is one or more bytes; the queue is decoded byte by byte
// [R2] one write puts one to four bytes into the command queue
// [R3] captured tdo bits go into the response queue for the debugger
// [R4] bit 7 clear: one-byte tms packet, one to five tms bits, one tdi level
// [R5] tms packet: bit 6 is tdi, highest set bit of 5..1 marks the length
// [R6] tms packets capture nothing and push nothing
// [R7] tdi held at the packet's bit 6 for all its tck cycles
// [R8] tms bits go out lsb first, one per tck cycle
// [R9] debugger splits tms sequences needing different tdi levels
// [R10] a scan packet is at least an opcode and a second byte
// [R11] packed tdi in the second byte only for scans under seven bits
// [R12] separate tdi data is one to sixteen bytes after the length byte
// [R13] scan header is recognised by top bits 1, 0, 0
// [R14] debugger writes opcode bit 4 as zero
// [R15] opcode bit 3 is the tms level on the last scan cycle
// [R16] tms low on every earlier scan cycle
// [R17] opcode bit 2 set: every tdo bit of the scan is stored
// [R18] debugger avoids capture with several targets selected
// [R19] opcode bit 1 is the fixed tdi level, used only when bit 0 is set
// [R20] opcode bit 0 set: no tdi data bytes, fixed level used
// [R21] second byte bit 7 clear: bits 6..0 are length minus one
// [R22] second byte bit 7 set: highest set bit of 6..1 marks length
// [R23] data bytes are length/8 rounded up, first tdi bit in bit 0
// [R24] reserved command bytes are dropped without tck or response
// [R25] tdo packed lsb first into bytes, last partial byte zero-filled
// [R26] decoding stalls on missing command bytes or full response queue
`timescale 1ns/1ps
`include "jtag_cmd_regs.svh"
module jtag_byte_engine #(
  parameter int CMD_DEPTH = 16,
  parameter int RSP_DEPTH = 16
) (
  // clocks, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  // command queue write
  input wire logic cmd_wr_i,
  input wire jtag_cmd_pkg::count_type cmd_count_i,
  input wire jtag_cmd_pkg::word_type cmd_data_i,
  output logic cmd_ack_o,
  output logic [$clog2(CMD_DEPTH):0] cmd_level_o,
  // response queue read
  input wire logic rsp_rd_i,
  input wire jtag_cmd_pkg::count_type rsp_count_i,
  output jtag_cmd_pkg::word_type rsp_data_o,
  output logic rsp_valid_o,
  output logic [$clog2(RSP_DEPTH):0] rsp_level_o,
  // status
  output logic busy_o,
  // jtag pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  import jtag_cmd_pkg::*;

  localparam int CAW = $clog2(CMD_DEPTH);
  localparam int RAW = $clog2(RSP_DEPTH);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // highest set bit among 6..1 gives the bit count, zero when none
  function automatic logic [2:0] marker_len(input logic [6:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 1; i < 7; i++) begin
      if (v[i]) begin
        n = 3'(i);
      end
    end
    return n;
  endfunction

  // a byte count from a port is legal from one to four
  function automatic logic count_ok(input count_type c);
    return (c != 3'h0) && (c <= `MAX_WR_BYTES);
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  scan_link_if lnk ();

  byte_type cmd_mem [CMD_DEPTH];
  byte_type rsp_mem [RSP_DEPTH];
  logic [CAW-1:0] cmd_wp_q, cmd_rp_q;
  logic [RAW-1:0] rsp_wp_q, rsp_rp_q;
  logic cmd_take, cmd_pop, cmd_have;
  logic rsp_take, rsp_push, rsp_room;
  byte_type cmd_head, acc_new;

  state_type state_q;
  logic [7:0] rem_q;
  byte_type sh_q;
  logic [2:0] bit_idx_q;
  logic tms_pkt_q;
  logic capture_out_flag_q;
  logic fixed_in_level_flag_q;
  logic lvl_q;
  logic end_tms_q;
  logic req_tgl_q, bit_tms_q, bit_tdi_q;
  logic ack_s1_q, ack_s2_q, ack_seen_q;
  logic ack_evt, last_bit;
  byte_type acc_q;
  logic [2:0] acc_n_q;

  // ----------------------------------------
  // link side
  // ----------------------------------------
  assign lnk.req_tgl = req_tgl_q;
  assign lnk.tms = bit_tms_q;
  assign lnk.tdi = bit_tdi_q;

  scan_link_phy u_scan_link_phy (
    .link_clk_i(link_clk_i),
    .rst_i(rst_i),
    .lnk(lnk),
    .tck_o(tck_o),
    .tms_o(tms_o),
    .tdi_o(tdi_o),
    .tdo_i(tdo_i)
  );

  // ack toggle comes from the link clock; two flops before use
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else if (ce_i) begin
      ack_s1_q <= lnk.ack_tgl;
      ack_s2_q <= ack_s1_q;
    end
  end

  assign ack_evt = (ack_s2_q != ack_seen_q) && (state_q == S_WAIT);
  assign last_bit = (rem_q == `ONE_BIT_LEFT);

  // ----------------------------------------
  // command queue
  // ----------------------------------------
  // a write that does not fit is ignored whole, never split
  assign cmd_take = cmd_wr_i && count_ok(cmd_count_i)
    && ((CAW+1)'(cmd_count_i) <= (CAW+1)'(CMD_DEPTH) - cmd_level_o); // R2
  assign cmd_have = (cmd_level_o != '0);
  assign cmd_head = cmd_mem[cmd_rp_q];
  // one byte is consumed per cycle in the fetching states
  assign cmd_pop = cmd_have
    && (state_q == S_OP || state_q == S_LEN || state_q == S_DATA); // R1

  // byte lanes land in order, lane 0 first
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && cmd_take) begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < cmd_count_i) begin
          cmd_mem[cmd_wp_q + CAW'(i)] <= cmd_data_i[8*i +: 8]; // R2
        end
      end
    end
  end

  // pointers and level
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_wp_q <= '0;
      cmd_rp_q <= '0;
      cmd_level_o <= '0;
      cmd_ack_o <= 1'b0;
    end else if (ce_i) begin
      cmd_ack_o <= cmd_take;
      if (cmd_take) begin
        cmd_wp_q <= cmd_wp_q + CAW'(cmd_count_i);
      end
      if (cmd_pop) begin
        cmd_rp_q <= cmd_rp_q + CAW'(1);
      end
      cmd_level_o <= cmd_level_o + (cmd_take ? (CAW+1)'(cmd_count_i) : '0)
        - (cmd_pop ? (CAW+1)'(1) : '0);
    end
  end

  // ----------------------------------------
  // response queue
  // ----------------------------------------
  // a read asking for more bytes than held is ignored; retry later
  assign rsp_take = rsp_rd_i && count_ok(rsp_count_i)
    && ((RAW+1)'(rsp_count_i) <= rsp_level_o);
  assign rsp_room = (rsp_level_o != (RAW+1)'(RSP_DEPTH));
  // new tdo bit merged into the byte being built
  assign acc_new = acc_q | (byte_type'(lnk.tdo_bit) << acc_n_q); // R25
  assign rsp_push = ack_evt && capture_out_flag_q
    && (acc_n_q == `LAST_BIT_IDX || last_bit); // R3

  always_ff @(posedge ref_clk_i) begin
    if (ce_i && rsp_push) begin
      rsp_mem[rsp_wp_q] <= acc_new; // R3
    end
  end

  // read data: first byte in the low lane, unused lanes zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rsp_rp_q <= '0;
      rsp_wp_q <= '0;
      rsp_level_o <= '0;
      rsp_data_o <= '0;
      rsp_valid_o <= 1'b0;
    end else if (ce_i) begin
      rsp_valid_o <= rsp_take;
      if (rsp_take) begin
        for (int i = 0; i < 4; i++) begin
          rsp_data_o[8*i +: 8] <= (3'(i) < rsp_count_i)
            ? rsp_mem[rsp_rp_q + RAW'(i)] : 8'h00;
        end
        rsp_rp_q <= rsp_rp_q + RAW'(rsp_count_i);
      end
      if (rsp_push) begin
        rsp_wp_q <= rsp_wp_q + RAW'(1);
      end
      rsp_level_o <= rsp_level_o + (rsp_push ? (RAW+1)'(1) : '0)
        - (rsp_take ? (RAW+1)'(rsp_count_i) : '0);
    end
  end

  // ----------------------------------------
  // tdo byte assembly
  // ----------------------------------------
  // a scan ending mid-byte pushes what it has, upper bits zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      acc_q <= 8'h00;
      acc_n_q <= 3'h0;
    end else if (ce_i && ack_evt && capture_out_flag_q) begin
      if (rsp_push) begin
        acc_q <= 8'h00; // R25
        acc_n_q <= 3'h0;
      end else begin
        acc_q <= acc_new; // R25
        acc_n_q <= acc_n_q + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // packet decoder
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= S_OP;
      rem_q <= 8'h00;
      sh_q <= 8'h00;
      bit_idx_q <= 3'h0;
      tms_pkt_q <= 1'b0;
      capture_out_flag_q <= 1'b0;
      fixed_in_level_flag_q <= 1'b0;
      lvl_q <= 1'b0;
      end_tms_q <= 1'b0;
      req_tgl_q <= 1'b0;
      bit_tms_q <= `TMS_IDLE;
      bit_tdi_q <= `TDI_IDLE;
      ack_seen_q <= 1'b0;
    end else if (ce_i) begin
      case (state_q)
        // opcode fetch; waits here while the queue is empty
        S_OP: begin
          if (cmd_have) begin // R26
            if (!cmd_head[`CMD_KIND_BIT]) begin // R4
              // bit 6 is excluded so the marker search covers 5..1
              if (marker_len({1'b0, cmd_head[5:0]}) != 3'h0) begin
                rem_q <= 8'(marker_len({1'b0, cmd_head[5:0]})); // R5
                sh_q <= {3'h0, cmd_head[4:0]}; // R5
                tms_pkt_q <= 1'b1;
                capture_out_flag_q <= 1'b0; // R6
                fixed_in_level_flag_q <= 1'b1;
                lvl_q <= cmd_head[`TMS_PKT_TDI_BIT]; // R7
                state_q <= S_BIT;
              end
            end else if (cmd_head[7:5] == `HDR_SCAN) begin // R13
              // bit 4 is not looked at
              tms_pkt_q <= 1'b0;
              end_tms_q <= cmd_head[`OP_END_TMS_BIT]; // R15
              capture_out_flag_q <= cmd_head[`OP_CAPTURE_BIT]; // R17
              lvl_q <= cmd_head[`OP_FIXED_LVL_BIT]; // R19
              fixed_in_level_flag_q <= cmd_head[`OP_FIXED_FLAG_BIT]; // R20
              state_q <= S_LEN; // R10
            end
            // other top bits: byte consumed and dropped R24
          end
        end
        // second byte: packed data or length
        S_LEN: begin
          if (cmd_have) begin // R26
            bit_idx_q <= 3'h0;
            if (cmd_head[`LEN_PACKED_BIT]) begin // R11
              rem_q <= 8'(marker_len(cmd_head[6:0])); // R22
              sh_q <= cmd_head; // R22
              // a packed byte with no marker carries no scan
              state_q <= (marker_len(cmd_head[6:0]) != 3'h0) ? S_BIT : S_OP;
            end else begin
              rem_q <= {1'b0, cmd_head[6:0]} + `ONE_BIT_LEFT; // R21
              state_q <= fixed_in_level_flag_q ? S_BIT : S_DATA; // R20
            end
          end
        end
        // next eight tdi bits
        S_DATA: begin
          if (cmd_have) begin // R26
            sh_q <= cmd_head; // R12
            state_q <= S_BIT;
          end
        end
        // issue one tck cycle; held back while capture has no room
        S_BIT: begin
          if (!capture_out_flag_q || rsp_room) begin // R26
            req_tgl_q <= ~req_tgl_q;
            if (tms_pkt_q) begin
              bit_tms_q <= sh_q[0]; // R8
            end else begin
              bit_tms_q <= last_bit ? end_tms_q : 1'b0; // R16
            end
            bit_tdi_q <= fixed_in_level_flag_q ? lvl_q : sh_q[0]; // R19
            state_q <= S_WAIT;
          end
        end
        // wait for the link to finish the cycle
        S_WAIT: begin
          if (ack_evt) begin
            ack_seen_q <= ack_s2_q;
            sh_q <= sh_q >> 1; // R8
            rem_q <= rem_q - `ONE_BIT_LEFT;
            bit_idx_q <= bit_idx_q + 3'h1;
            if (last_bit) begin
              state_q <= S_OP;
            end else if (!fixed_in_level_flag_q && bit_idx_q == `LAST_BIT_IDX) begin
              state_q <= S_DATA; // R23
            end else begin
              state_q <= S_BIT;
            end
          end
        end
        default: begin
          state_q <= S_OP;
        end
      endcase
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  // busy while a packet is part way through
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (state_q != S_OP);
    end
  end
endmodule

/* File: testbench/jtag_tap_model.sv */
`timescale 1ns/1ps
module jtag_tap_model (
  // jtag pins seen from the target
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o
);
  logic [15:0] lfsr_q;

  // the only selected target shifts tdo out on the falling tck edge; the
  // small delay keeps the change clear of the engine's sampling edge
  initial begin
    lfsr_q = 16'hACE1;
    tdo_o = 1'b0;
  end
  always @(negedge tck_i) begin
    lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[12] ^ tms_i ^ tdi_i};
    tdo_o <= #1 lfsr_q[0] ^ tdi_i;
  end
endmodule

/* File: testbench/jtag_byte_engine_sva.sv */
`timescale 1ns/1ps
module jtag_byte_engine_sva #(
  parameter int CMD_DEPTH = 16,
  parameter int RSP_DEPTH = 16
) (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic cmd_wr_i,
  input wire jtag_cmd_pkg::count_type cmd_count_i,
  input wire logic cmd_ack_o,
  input wire logic [$clog2(CMD_DEPTH):0] cmd_level_o,
  input wire logic rsp_rd_i,
  input wire jtag_cmd_pkg::count_type rsp_count_i,
  input wire jtag_cmd_pkg::word_type rsp_data_o,
  input wire logic rsp_valid_o,
  input wire logic [$clog2(RSP_DEPTH):0] rsp_level_o,
  input wire logic tck_o,
  input wire logic tms_o,
  input wire logic tdi_o
);
  import jtag_cmd_pkg::*;
  logic wr_ok;
  logic rd_ok;
  // ---------------
  // queue handshakes
  // ---------------
  // a request is taken only whole: legal count and room or data for all of it
  assign wr_ok = ce_i && cmd_wr_i && cmd_count_i != 3'h0 && cmd_count_i <= 3'h4 &&
    int'(cmd_count_i) <= CMD_DEPTH - int'(cmd_level_o);
  assign rd_ok = ce_i && rsp_rd_i && rsp_count_i != 3'h0 && rsp_count_i <= 3'h4 &&
    int'(rsp_count_i) <= int'(rsp_level_o);
  property p_ack;
    @(posedge ref_clk_i) disable iff (rst_i) wr_ok |=> cmd_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("write not acked");
  property p_stall;
    @(posedge ref_clk_i) disable iff (rst_i) !wr_ok |=> !cmd_ack_o;
  endproperty
  a_stall: assert property (p_stall) else $error("refused write acked");
  property p_ack_lvl;
    @(posedge ref_clk_i) disable iff (rst_i)
      cmd_ack_o |-> int'(cmd_level_o) + 1 >= int'($past(cmd_count_i));
  endproperty
  a_ack_lvl: assert property (p_ack_lvl) else $error("level misses write");
  property p_rd;
    @(posedge ref_clk_i) disable iff (rst_i) rd_ok |=> rsp_valid_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rd_ref;
    @(posedge ref_clk_i) disable iff (rst_i) !rd_ok |=> !rsp_valid_o;
  endproperty
  a_rd_ref: assert property (p_rd_ref) else $error("short read answered");
  property p_hold;
    @(posedge ref_clk_i) disable iff (rst_i) !rsp_valid_o |-> $stable(rsp_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_lane;
    @(posedge ref_clk_i) disable iff (rst_i)
      rsp_valid_o && $past(rsp_count_i) == 3'h1 |-> rsp_data_o[31:8] == 24'h00_0000;
  endproperty
  a_lane: assert property (p_lane) else $error("upper lanes not zero");
  // ---------------
  // link pins
  // ---------------
  property p_tck;
    @(posedge link_clk_i) disable iff (rst_i) $rose(tck_o) |-> tck_o [*3] ##1 !tck_o;
  endproperty
  a_tck: assert property (p_tck) else $error("tck high width");
  property p_pins;
    @(posedge link_clk_i) disable iff (rst_i)
      tck_o && $past(tck_o) |-> $stable(tms_o) && $stable(tdi_o);
  endproperty
  a_pins: assert property (p_pins) else $error("pins moved with tck high");
  c_stall: cover property (@(posedge ref_clk_i) cmd_wr_i && !wr_ok);
  c_rd4: cover property (@(posedge ref_clk_i) rd_ok && rsp_count_i == 3'h4);
  c_tck: cover property (@(posedge link_clk_i) $rose(tck_o) && tms_o);
endmodule

bind jtag_byte_engine jtag_byte_engine_sva #(.CMD_DEPTH(CMD_DEPTH), .RSP_DEPTH(RSP_DEPTH)) u_sva (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link_clk_i(link_clk_i),
  .cmd_wr_i(cmd_wr_i), .cmd_count_i(cmd_count_i), .cmd_ack_o(cmd_ack_o),
  .cmd_level_o(cmd_level_o), .rsp_rd_i(rsp_rd_i), .rsp_count_i(rsp_count_i),
  .rsp_data_o(rsp_data_o), .rsp_valid_o(rsp_valid_o), .rsp_level_o(rsp_level_o),
  .tck_o(tck_o), .tms_o(tms_o), .tdi_o(tdi_o));

/* File: testbench/jtag_byte_engine_bench.sv */
`timescale 1ns/1ps
module jtag_byte_engine_bench;
  import jtag_cmd_pkg::*;
  typedef struct packed {logic tms; logic tdi; logic cap; logic last;} cyc_type;
  logic ref_clk_i, link_clk_i, rst_i, ce_i, cmd_wr_i, rsp_rd_i;
  count_type cmd_count_i, rsp_count_i;
  word_type cmd_data_i, rsp_data_o;
  logic cmd_ack_o, rsp_valid_o, busy_o, tck_o, tms_o, tdi_o, tdo_i;
  logic [3:0] cmd_level_o;
  logic [2:0] rsp_level_o;
  logic [31:0] seed = 32'h0001_135D;
  logic [7:0] acc = 8'h00;
  int nacc = 0;
  int n_errors = 0;
  int checks = 0;
  cyc_type tq[$];
  byte_type rq[$];
  byte_type cmd[$];
  word_type wq[$];
  // ---------------
  // clocks and parts
  // ---------------
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // link clock offset so its edges never line up with the main clock
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  // small queues so both stalls are reached quickly
  jtag_byte_engine #(.CMD_DEPTH(8), .RSP_DEPTH(4)) u_jtag_byte_engine (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link_clk_i(link_clk_i),
    .cmd_wr_i(cmd_wr_i), .cmd_count_i(cmd_count_i), .cmd_data_i(cmd_data_i),
    .cmd_ack_o(cmd_ack_o), .cmd_level_o(cmd_level_o), .rsp_rd_i(rsp_rd_i),
    .rsp_count_i(rsp_count_i), .rsp_data_o(rsp_data_o), .rsp_valid_o(rsp_valid_o),
    .rsp_level_o(rsp_level_o), .busy_o(busy_o), .tck_o(tck_o), .tms_o(tms_o),
    .tdi_o(tdi_o), .tdo_i(tdo_i));
  jtag_tap_model u_jtag_tap_model (.tck_i(tck_o), .tms_i(tms_o), .tdi_i(tdi_o),
    .tdo_o(tdo_i));
  // ---------------
  // helpers
  // ---------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input word_type seen, input word_type exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // writes of one to four bytes, each held until acked; a full queue stalls it
  task automatic send();
    int n;
    int k;
    while (cmd.size() > 0) begin
      n = rnd() % 4 + 1;
      if (n > cmd.size()) n = cmd.size();
      @(posedge ref_clk_i);
      #2;
      cmd_count_i = 3'(n);
      cmd_data_i = 32'h0000_0000;
      for (int i = 0; i < n; i++) cmd_data_i[8*i +: 8] = cmd.pop_front();
      cmd_wr_i = 1'b1;
      k = 0;
      do begin
        @(posedge ref_clk_i);
        #2;
        k++;
      end while (cmd_ack_o !== 1'b1 && k < 3000);
      cmd_wr_i = 1'b0;
      if (k >= 3000) begin
        n_errors++;
        results();
      end
    end
  endtask
  // one tms packet; a new tdi level always needs a new packet
  task automatic tms_pkt(input int len, input logic lvl, input logic [4:0] bits);
    logic [7:0] b;
    b = {1'b0, lvl, 6'h00};
    b[len] = 1'b1;
    for (int i = 0; i < len; i++) begin
      b[i] = bits[i];
      tq.push_back('{bits[i], lvl, 1'b0, 1'b0});
    end
    cmd.push_back(b);
    send();
  endtask
  // one scan packet; v[0] is the first tdi bit, bits past len are zero
  task automatic scan(input logic [7:0] op, input int len, input logic pk);
    logic [127:0] v;
    logic [7:0] b;
    for (int i = 0; i < 128; i++) v[i] = (i < len) ? rnd() % 2 : 1'b0;
    cmd.push_back(op);
    if (pk) begin
      b = 8'h80;
      b[len] = 1'b1;
      for (int i = 0; i < len; i++) b[i] = v[i];
      cmd.push_back(b);
    end else begin
      cmd.push_back(8'(len - 1));
      for (int i = 0; i < len && !op[0]; i += 8) cmd.push_back(v[i +: 8]);
    end
    for (int i = 0; i < len; i++) begin
      tq.push_back('{(i == len - 1) ? op[3] : 1'b0, op[0] ? op[1] : v[i], op[2],
        i == len - 1});
    end
    send();
  endtask
  // ---------------
  // watchers and reader
  // ---------------
  // each tck rise is compared with the oldest expected cycle; tdo is packed
  always @(posedge tck_o) begin
    if (tq.size() == 0) begin
      check(tck_o, 1'b0);
    end else begin
      check(tms_o, tq[0].tms);
      check(tdi_o, tq[0].tdi);
      check(busy_o, 1'b1);
      if (tq[0].cap) begin
        acc[nacc] = tdo_i;
        nacc++;
      end
      if (tq[0].cap && (nacc == 8 || tq[0].last)) begin
        rq.push_back(acc);
        acc = 8'h00;
        nacc = 0;
      end
      void'(tq.pop_front());
    end
  end
  always @(negedge ref_clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      check(rsp_data_o, wq.size() > 0 ? wq.pop_front() : 32'hxxxx_xxxx);
    end
  end
  // reads at random moments so the response queue also fills and stalls
  initial begin
    word_type w;
    int n;
    rsp_rd_i = 1'b0;
    rsp_count_i = 3'h1;
    wait (rst_i === 1'b0);
    forever begin
      repeat (rnd() % 48) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      #2;
      n = rnd() % 4 + 1;
      if (n <= rsp_level_o && n <= rq.size()) begin
        w = 32'h0000_0000;
        for (int i = 0; i < n; i++) w[8*i +: 8] = rq.pop_front();
        wq.push_back(w);
      end
      rsp_count_i = 3'(n);
      rsp_rd_i = 1'b1;
      @(posedge ref_clk_i);
      #2;
      rsp_rd_i = 1'b0;
    end
  end
  // ---------------
  // main sequence
  // ---------------
  initial begin
    int k;
    rst_i = 1'b1;
    ce_i = 1'b1;
    cmd_wr_i = 1'b0;
    cmd_count_i = 3'h1;
    cmd_data_i = 32'h0000_0000;
    repeat (10) @(posedge ref_clk_i);
    #2;
    rst_i = 1'b0;
    for (int i = 1; i <= 5; i++) begin
      tms_pkt(i, 1'b0, 5'(rnd()));
      tms_pkt(i, 1'b1, 5'(rnd()));
    end
    cmd = '{8'hA3, 8'hC0, 8'hFF, 8'h40};
    send();
    scan(8'h8C, 21, 1'b0);
    for (int i = 1; i <= 6; i++) scan(8'h84 | 8'(rnd() & 32'h0000_000B), i, 1'b1);
    scan(8'h80, 128, 1'b0);
    scan(8'h87, 7, 1'b0);
    scan(8'h86, 9, 1'b0);
    scan(8'h84, 128, 1'b0);
    k = 0;
    while ((tq.size() > 0 || rq.size() > 0 || wq.size() > 0 || busy_o !== 1'b0) &&
      k < 20000) begin
      @(posedge ref_clk_i);
      k++;
    end
    repeat (30) @(posedge ref_clk_i);
    // a frozen engine must neither take a write nor start a tms cycle
    #2;
    ce_i = 1'b0;
    cmd_count_i = 3'h1;
    cmd_data_i = 32'h0000_0002;
    cmd_wr_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #2;
    check(cmd_level_o, 4'h0);
    cmd_wr_i = 1'b0;
    ce_i = 1'b1;
    repeat (30) @(posedge ref_clk_i);
    check(rsp_level_o, 3'h0);
    check(cmd_level_o, 4'h0);
    if (k >= 20000) n_errors++;
    results();
  end
endmodule
